// ==== verilog/bdr_pkg.sv ====
// Shared constants for the backup-domain real-time clock
package bdr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;
    localparam int PRESC_W = 20;
    localparam int CNT_W  = 32;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] OFF_CTRL_STAT  = 8'h04;
    localparam logic [7:0] OFF_PRESC_HI   = 8'h08;
    localparam logic [7:0] OFF_PRESC_LO   = 8'h0C;
    localparam logic [7:0] OFF_DIV_HI     = 8'h10;
    localparam logic [7:0] OFF_DIV_LO     = 8'h14;
    localparam logic [7:0] OFF_COUNT_HI   = 8'h18;
    localparam logic [7:0] OFF_COUNT_LO   = 8'h1C;
    localparam logic [7:0] OFF_ALARM_HI   = 8'h20;
    localparam logic [7:0] OFF_ALARM_LO   = 8'h24;

    // irq_enable fields
    localparam int BIT_TICK_IE  = 0;
    localparam int BIT_ALARM_IE = 1;
    localparam int BIT_OVF_IE   = 2;
    // control_status fields
    localparam int BIT_TICK_F   = 0;
    localparam int BIT_ALARM_F  = 1;
    localparam int BIT_OVF_F    = 2;
    localparam int BIT_SYNC_F   = 3;
    localparam int BIT_CFG_F    = 4;
    localparam int BIT_WDONE_F  = 5;

    // Reset values
    localparam logic [15:0] RST_IRQ_ENABLE = 16'h0000;
    localparam logic [15:0] RST_CTRL_STAT  = 16'h0020;
    localparam logic [19:0] RST_PRESC      = 20'h08000;
    localparam logic [19:0] RST_DIV        = 20'h08000;
    localparam logic [31:0] RST_COUNT      = 32'h00000000;
    localparam logic [31:0] RST_ALARM      = 32'hFFFFFFFF;

    // Timing counts in core source clock edges
    localparam int FAST_DIV_W     = 7;
    localparam int FAST_DIV       = 128;
    localparam int CORE_LAG_EDGES = 3;

    // Core source selection
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_SLOW = 2'h1;
    localparam logic [1:0] SRC_INT  = 2'h2;
    localparam logic [1:0] SRC_FAST = 2'h3;
endpackage : bdr_pkg

// ==== verilog/bdr_apb_if.sv ====
// Peripheral bus between processor end and clock device end
interface bdr_apb_if;
    logic                      PSEL;
    logic                      PENABLE;
    logic                      PWRITE;
    logic [bdr_pkg::ADDR_W-1:0] PADDR;
    logic [bdr_pkg::DATA_W-1:0] PWDATA;
    logic [bdr_pkg::DATA_W-1:0] PRDATA;
    logic                      PREADY;
    logic                      PSLVERR;

    modport dev  (input  PSEL, PENABLE, PWRITE, PADDR, PWDATA,
                  output PRDATA, PREADY, PSLVERR);
    modport host (output PSEL, PENABLE, PWRITE, PADDR, PWDATA,
                  input  PRDATA, PREADY, PSLVERR);
endinterface : bdr_apb_if

// ==== verilog/bdr_sync.sv ====
// Two-stage synchroniser with rising-edge detect after the second stage
module bdr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             CLK,
    input  wire logic             RST_N,
    input  wire logic [WIDTH-1:0] ASYNC_IN,
    output logic      [WIDTH-1:0] LEVEL,
    output logic      [WIDTH-1:0] RISE
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] s1_d;
    logic [WIDTH-1:0] s2_d;
    logic [WIDTH-1:0] s3_d;

    always_comb begin
        s1_d = ASYNC_IN;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    assign LEVEL = s2_q;
    assign RISE  = s2_q & ~s3_q;
endmodule : bdr_sync

// ==== verilog/bdr_device.sv ====
// Clock device end: bus registers, core divider, counter, alarm, flags
//
// Overview of operation
// R1: Counter, alarm, prescaler, divider kept in backup domain
// R2: Twenty-bit divider derives the seconds tick
// R3: Source clock at most quarter bus clock
// R4: Source: fast crystal/128, slow crystal, internal oscillator
// R5: Tick enable requests interrupt every tick
// R6: Alarm enable requests interrupt on alarm match
// R7: System reset clears bus side; backup reset core
// R8: Counter, divider readable, refreshed each core edge
// R9: Sync flag cleared by software, set on resync
// R10: Core writes accepted only in configuration mode
// R11: Writes apply three core edges after exit
// R12: Software waits write-done around each configuration
// R13: Tick flag set in cycle before increment
// R14: Alarm flag set before counter reaches alarm+1
// R15: Overflow flag set before counter wraps to zero
// R16: Software updates alarm/counter synchronised to tick
// R17: Enable bits: overflow 2, alarm 1, tick 0
// R18: Control layout bits 5..0, reset 0x0020
// R19: Alarm flag drives global and alarm lines
// R20: Tick flag set as divider reaches zero, before reload and increment
// R21: Tick rate is source over prescale plus one
// R22: Divider reloads on prescale or counter update
// R23: Flags cleared by writing zero only
module bdr_device (
    input  wire logic  CLK,
    input  wire logic  RST_N,
    input  wire logic  BKP_RST_N,
    input  wire logic  [1:0] SRC_SEL,
    input  wire logic  FAST_XTAL,
    input  wire logic  SLOW_XTAL,
    input  wire logic  INT_OSC,
    bdr_apb_if.dev     BUS,
    output logic       IRQ,
    output logic       ALARM_LINE
);
    localparam logic [1:0] LAG_LAST = 2'(bdr_pkg::CORE_LAG_EDGES - 1);
    localparam logic [bdr_pkg::FAST_DIV_W-1:0] FAST_LAST =
        bdr_pkg::FAST_DIV_W'(bdr_pkg::FAST_DIV - 1);

    logic [2:0] clk_rise;
    logic [1:0] sel_lvl;
    logic       core_edge;

    // Core state, backup reset only
    logic [19:0] presc_q, presc_d;
    logic [19:0] div_q,   div_d;
    logic [31:0] cnt_q,   cnt_d;
    logic [31:0] alarm_q, alarm_d;
    logic [bdr_pkg::FAST_DIV_W-1:0] fdiv_q, fdiv_d;

    // Bus side state, system reset
    logic [2:0]  ien_q,   ien_d;
    logic        tick_q,  tick_d;
    logic        alrm_q,  alrm_d;
    logic        ovf_q,   ovf_d;
    logic        sync_q,  sync_d;
    logic        cfg_q,   cfg_d;
    logic        wdone_q, wdone_d;
    logic [1:0]  lag_q,   lag_d;
    logic [19:0] st_presc_q, st_presc_d;
    logic [31:0] st_cnt_q,   st_cnt_d;
    logic [31:0] st_alarm_q, st_alarm_d;
    logic [2:0]  pend_q,  pend_d;
    logic [19:0] div_sh_q, div_sh_d;
    logic [31:0] cnt_sh_q, cnt_sh_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        irq_q,   irq_d;
    logic        aline_q, aline_d;

    logic        setup;
    logic        wr;
    logic        apply;
    logic        tick_ev;
    logic        mapped;
    logic [15:0] wd;

    // Source pins are asynchronous; they stay alive through system reset
    bdr_sync #(.WIDTH(3)) u_clk_sync (
        .CLK      (CLK),
        .RST_N    (BKP_RST_N),
        .ASYNC_IN ({FAST_XTAL, SLOW_XTAL, INT_OSC}),
        .LEVEL    (),
        .RISE     (clk_rise)
    );

    bdr_sync #(.WIDTH(2)) u_sel_sync (
        .CLK      (CLK),
        .RST_N    (BKP_RST_N),
        .ASYNC_IN (SRC_SEL),
        .LEVEL    (sel_lvl),
        .RISE     ()
    );

    always_comb begin
        // Edges must be at least four bus cycles apart to be seen // R3
        core_edge = 1'b0;
        fdiv_d    = fdiv_q;
        if (clk_rise[2]) begin
            fdiv_d = fdiv_q + 1'b1;
        end
        if (sel_lvl == bdr_pkg::SRC_FAST) begin // R4
            core_edge = clk_rise[2] && (fdiv_q == FAST_LAST);
        end else if (sel_lvl == bdr_pkg::SRC_SLOW) begin
            core_edge = clk_rise[1];
        end else if (sel_lvl == bdr_pkg::SRC_INT) begin
            core_edge = clk_rise[0];
        end
    end

    always_comb begin
        presc_d    = presc_q;
        div_d      = div_q;
        cnt_d      = cnt_q;
        alarm_d    = alarm_q;
        ien_d      = ien_q;
        tick_d     = tick_q;
        alrm_d     = alrm_q;
        ovf_d      = ovf_q;
        sync_d     = sync_q;
        cfg_d      = cfg_q;
        wdone_d    = wdone_q;
        lag_d      = lag_q;
        st_presc_d = st_presc_q;
        st_cnt_d   = st_cnt_q;
        st_alarm_d = st_alarm_q;
        pend_d     = pend_q;
        div_sh_d   = div_sh_q;
        cnt_sh_d   = cnt_sh_q;
        tick_ev    = 1'b0;
        apply      = 1'b0;
        wd         = BUS.PWDATA[15:0];
        setup      = BUS.PSEL && !BUS.PENABLE;
        wr         = BUS.PSEL && BUS.PENABLE && pready_q && BUS.PWRITE;

        // Setup phase: decode address and register the answer
        mapped   = 1'b1;
        prdata_d = '0;
        if (BUS.PADDR == bdr_pkg::OFF_IRQ_ENABLE) begin
            prdata_d[2:0] = ien_q;
        end else if (BUS.PADDR == bdr_pkg::OFF_CTRL_STAT) begin
            prdata_d[5:0] = {wdone_q, cfg_q, sync_q, ovf_q, alrm_q, tick_q};
        end else if (BUS.PADDR == bdr_pkg::OFF_DIV_HI) begin
            prdata_d[3:0] = div_sh_q[19:16]; // R8
        end else if (BUS.PADDR == bdr_pkg::OFF_DIV_LO) begin
            prdata_d[15:0] = div_sh_q[15:0];
        end else if (BUS.PADDR == bdr_pkg::OFF_COUNT_HI) begin
            prdata_d[15:0] = cnt_sh_q[31:16];
        end else if (BUS.PADDR == bdr_pkg::OFF_COUNT_LO) begin
            prdata_d[15:0] = cnt_sh_q[15:0];
        end else if (BUS.PADDR == bdr_pkg::OFF_PRESC_HI
                  || BUS.PADDR == bdr_pkg::OFF_PRESC_LO
                  || BUS.PADDR == bdr_pkg::OFF_ALARM_HI
                  || BUS.PADDR == bdr_pkg::OFF_ALARM_LO) begin
            prdata_d = '0; // Write-only core values
        end else begin
            mapped = 1'b0;
        end
        prdata_d  = setup ? prdata_d : '0;
        pready_d  = setup;
        pslverr_d = setup && !mapped;

        // Access phase writes
        if (wr) begin
            if (BUS.PADDR == bdr_pkg::OFF_IRQ_ENABLE) begin
                ien_d = wd[2:0]; // R17
            end else if (BUS.PADDR == bdr_pkg::OFF_CTRL_STAT) begin
                // Zero clears, one leaves alone // R23
                tick_d = tick_q && wd[bdr_pkg::BIT_TICK_F];
                alrm_d = alrm_q && wd[bdr_pkg::BIT_ALARM_F];
                ovf_d  = ovf_q  && wd[bdr_pkg::BIT_OVF_F];
                sync_d = sync_q && wd[bdr_pkg::BIT_SYNC_F]; // R9
                cfg_d  = wd[bdr_pkg::BIT_CFG_F]; // R18
                if (cfg_q && !wd[bdr_pkg::BIT_CFG_F]) begin
                    wdone_d = 1'b0; // R11
                    lag_d   = '0;
                end
            end else if (cfg_q) begin // R10
                if (BUS.PADDR == bdr_pkg::OFF_PRESC_HI) begin
                    st_presc_d[19:16] = wd[3:0];
                    pend_d[0] = 1'b1;
                end else if (BUS.PADDR == bdr_pkg::OFF_PRESC_LO) begin
                    st_presc_d[15:0] = wd;
                    pend_d[0] = 1'b1;
                end else if (BUS.PADDR == bdr_pkg::OFF_COUNT_HI) begin
                    st_cnt_d[31:16] = wd;
                    pend_d[1] = 1'b1;
                end else if (BUS.PADDR == bdr_pkg::OFF_COUNT_LO) begin
                    st_cnt_d[15:0] = wd;
                    pend_d[1] = 1'b1;
                end else if (BUS.PADDR == bdr_pkg::OFF_ALARM_HI) begin
                    st_alarm_d[31:16] = wd;
                    pend_d[2] = 1'b1;
                end else if (BUS.PADDR == bdr_pkg::OFF_ALARM_LO) begin
                    st_alarm_d[15:0] = wd;
                    pend_d[2] = 1'b1;
                end
            end
        end

        // Transfer of staged values, third core edge after exit
        if (!wdone_q && !cfg_q && core_edge) begin
            if (lag_q == LAG_LAST) begin // R11
                apply   = 1'b1;
                wdone_d = 1'b1;
                pend_d  = '0;
            end else begin
                lag_d = lag_q + 1'b1;
            end
        end

        if (apply) begin
            if (pend_q[0]) begin
                presc_d = st_presc_q;
            end
            if (pend_q[1]) begin
                cnt_d = st_cnt_q;
            end
            if (pend_q[2]) begin
                alarm_d = st_alarm_q;
            end
            if (pend_q[0] || pend_q[1]) begin
                div_d = pend_q[0] ? st_presc_q : presc_q; // R22
            end
        end else if (core_edge) begin
            if (div_q == '0) begin
                div_d = presc_q; // R20 R21
                cnt_d = cnt_q + 1'b1; // R1
            end else begin
                div_d = div_q - 1'b1; // R2
            end
            // Flags rise while divider sits at zero, before the step
            tick_ev = (div_d == '0);
        end

        // Set beats a simultaneous software clear
        if (tick_ev) begin
            tick_d = 1'b1; // R13
            if (cnt_q == alarm_q) begin
                alrm_d = 1'b1; // R14
            end
            if (cnt_q == '1) begin
                ovf_d = 1'b1; // R15
            end
        end

        // Read copies refresh on every core edge // R8
        if (core_edge) begin
            div_sh_d = div_q;
            cnt_sh_d = cnt_q;
            sync_d   = 1'b1; // R9
        end

        irq_d = (tick_q && ien_q[bdr_pkg::BIT_TICK_IE]) // R5
             || (alrm_q && ien_q[bdr_pkg::BIT_ALARM_IE]) // R6 R19
             || (ovf_q  && ien_q[bdr_pkg::BIT_OVF_IE]);
        aline_d = alrm_q; // R19
    end

    // Core survives system reset // R7
    always_ff @(posedge CLK) begin
        if (!BKP_RST_N) begin
            presc_q <= bdr_pkg::RST_PRESC;
            div_q   <= bdr_pkg::RST_DIV;
            cnt_q   <= bdr_pkg::RST_COUNT;
            alarm_q <= bdr_pkg::RST_ALARM;
            fdiv_q  <= '0;
        end else begin
            presc_q <= presc_d;
            div_q   <= div_d;
            cnt_q   <= cnt_d;
            alarm_q <= alarm_d;
            fdiv_q  <= fdiv_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin // R7
            ien_q      <= bdr_pkg::RST_IRQ_ENABLE[2:0];
            tick_q     <= bdr_pkg::RST_CTRL_STAT[bdr_pkg::BIT_TICK_F];
            alrm_q     <= bdr_pkg::RST_CTRL_STAT[bdr_pkg::BIT_ALARM_F];
            ovf_q      <= bdr_pkg::RST_CTRL_STAT[bdr_pkg::BIT_OVF_F];
            sync_q     <= bdr_pkg::RST_CTRL_STAT[bdr_pkg::BIT_SYNC_F];
            cfg_q      <= bdr_pkg::RST_CTRL_STAT[bdr_pkg::BIT_CFG_F];
            wdone_q    <= bdr_pkg::RST_CTRL_STAT[bdr_pkg::BIT_WDONE_F];
            lag_q      <= '0;
            st_presc_q <= bdr_pkg::RST_PRESC;
            st_cnt_q   <= bdr_pkg::RST_COUNT;
            st_alarm_q <= bdr_pkg::RST_ALARM;
            pend_q     <= '0;
            div_sh_q   <= '0;
            cnt_sh_q   <= '0;
            prdata_q   <= '0;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            irq_q      <= 1'b0;
            aline_q    <= 1'b0;
        end else begin
            ien_q      <= ien_d;
            tick_q     <= tick_d;
            alrm_q     <= alrm_d;
            ovf_q      <= ovf_d;
            sync_q     <= sync_d;
            cfg_q      <= cfg_d;
            wdone_q    <= wdone_d;
            lag_q      <= lag_d;
            st_presc_q <= st_presc_d;
            st_cnt_q   <= st_cnt_d;
            st_alarm_q <= st_alarm_d;
            pend_q     <= pend_d;
            div_sh_q   <= div_sh_d;
            cnt_sh_q   <= cnt_sh_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            irq_q      <= irq_d;
            aline_q    <= aline_d;
        end
    end

    assign BUS.PRDATA  = prdata_q;
    assign BUS.PREADY  = pready_q;
    assign BUS.PSLVERR = pslverr_q;
    assign IRQ         = irq_q;
    assign ALARM_LINE  = aline_q;
endmodule : bdr_device

// ==== verilog/bdr_host.sv ====
// Processor end: turns single commands into peripheral bus transfers
module bdr_host (
    input  wire logic         CLK,
    input  wire logic         RST_N,
    bdr_apb_if.host           BUS,
    input  wire logic         CMD_VALID,
    input  wire logic         CMD_WRITE,
    input  wire logic [7:0]   CMD_ADDR,
    input  wire logic [31:0]  CMD_WDATA,
    output logic              CMD_READY,
    output logic              RSP_VALID,
    output logic [31:0]       RSP_RDATA,
    output logic              RSP_ERR
);
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS} bdr_hst_e;

    bdr_hst_e    st_q,    st_d;
    logic        psel_q,  psel_d;
    logic        pen_q,   pen_d;
    logic        pwr_q,   pwr_d;
    logic [7:0]  paddr_q, paddr_d;
    logic [31:0] pwd_q,   pwd_d;
    logic        rdy_q,   rdy_d;
    logic        rv_q,    rv_d;
    logic [31:0] rd_q,    rd_d;
    logic        err_q,   err_d;

    // Software ordering of configuration steps is the caller's duty // R12 R16
    always_comb begin
        st_d    = st_q;
        psel_d  = psel_q;
        pen_d   = pen_q;
        pwr_d   = pwr_q;
        paddr_d = paddr_q;
        pwd_d   = pwd_q;
        rdy_d   = rdy_q;
        rv_d    = 1'b0;
        rd_d    = rd_q;
        err_d   = err_q;
        case (st_q)
            ST_IDLE: begin
                if (CMD_VALID && rdy_q) begin
                    st_d    = ST_SETUP;
                    psel_d  = 1'b1;
                    pwr_d   = CMD_WRITE;
                    paddr_d = CMD_ADDR;
                    pwd_d   = CMD_WRITE ? CMD_WDATA : '0;
                    rdy_d   = 1'b0;
                end
            end
            ST_SETUP: begin
                st_d  = ST_ACCESS;
                pen_d = 1'b1;
            end
            ST_ACCESS: begin
                if (BUS.PREADY) begin
                    st_d   = ST_IDLE;
                    psel_d = 1'b0;
                    pen_d  = 1'b0;
                    rdy_d  = 1'b1;
                    rv_d   = 1'b1;
                    rd_d   = pwr_q ? '0 : BUS.PRDATA;
                    err_d  = BUS.PSLVERR;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_q    <= ST_IDLE;
            psel_q  <= 1'b0;
            pen_q   <= 1'b0;
            pwr_q   <= 1'b0;
            paddr_q <= '0;
            pwd_q   <= '0;
            rdy_q   <= 1'b1;
            rv_q    <= 1'b0;
            rd_q    <= '0;
            err_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            psel_q  <= psel_d;
            pen_q   <= pen_d;
            pwr_q   <= pwr_d;
            paddr_q <= paddr_d;
            pwd_q   <= pwd_d;
            rdy_q   <= rdy_d;
            rv_q    <= rv_d;
            rd_q    <= rd_d;
            err_q   <= err_d;
        end
    end

    assign BUS.PSEL    = psel_q;
    assign BUS.PENABLE = pen_q;
    assign BUS.PWRITE  = pwr_q;
    assign BUS.PADDR   = paddr_q;
    assign BUS.PWDATA  = pwd_q;
    assign CMD_READY   = rdy_q;
    assign RSP_VALID   = rv_q;
    assign RSP_RDATA   = rd_q;
    assign RSP_ERR     = err_q;
endmodule : bdr_host

// ==== bench/bdr_chk.sv ====
// Bus-side assertions for the clock device register port
module bdr_chk (
    input wire logic                       CLK,
    input wire logic                       RST_N,
    input wire logic                       PSEL,
    input wire logic                       PENABLE,
    input wire logic                       PWRITE,
    input wire logic [bdr_pkg::ADDR_W-1:0] PADDR,
    input wire logic [bdr_pkg::DATA_W-1:0] PWDATA,
    input wire logic [bdr_pkg::DATA_W-1:0] PRDATA,
    input wire logic                       PREADY,
    input wire logic                       PSLVERR
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    logic       rd_ok;
    logic       setup;
    logic [2:0] ie_d;
    logic [2:0] ie_q;

    assign rd_ok = PREADY && !PWRITE;
    assign setup = PSEL && !PENABLE;

    // Shadow of the enables, cleared with the bus side
    always_comb begin
        ie_d = ie_q;
        if (PREADY && PWRITE && PADDR == bdr_pkg::OFF_IRQ_ENABLE) begin
            ie_d = PWDATA[2:0];
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ie_q <= 3'h0;
        end else begin
            ie_q <= ie_d;
        end
    end

    setup_ready_a: assert property (setup |=> PREADY && $stable(PADDR))
        else $error("no ready in the access cycle");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    err_unmapped_a: assert property (setup && PADDR > 8'h24 |=> PSLVERR)
        else $error("unmapped offset not refused");
    err_ready_a: assert property (PSLVERR |-> PREADY && PSEL)
        else $error("error without ready");
    idle_rdata_a: assert property (!PREADY |-> PRDATA == '0)
        else $error("read data outside the access cycle");
    ie_reserved_a: assert property (rd_ok && PADDR == 8'h00 |->
        PRDATA[31:3] == '0) else $error("enable reserved bits set");
    ctl_reserved_a: assert property (rd_ok && PADDR == 8'h04 |->
        PRDATA[31:6] == '0) else $error("control reserved bits set");
    wo_zero_a: assert property (rd_ok && PADDR == 8'h0C |-> PRDATA == '0)
        else $error("prescaler read back nonzero");
    ie_readback_a: assert property (rd_ok && PADDR == 8'h00 |->
        PRDATA[2:0] == ie_q) else $error("enable read differs from written");

    wr_c: cover property (PREADY && PWRITE);
    rd_c: cover property (rd_ok && PADDR == 8'h04 && PRDATA[0]);
    err_c: cover property (PSLVERR);
endmodule : bdr_chk

// ==== bench/tb_backup_domain_rtc.sv ====
// Self-checking bench: processor end driving the clock device end
module tb_backup_domain_rtc;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] A_IE = bdr_pkg::OFF_IRQ_ENABLE;
    localparam logic [7:0] A_CT = bdr_pkg::OFF_CTRL_STAT;
    localparam logic [7:0] A_CL = bdr_pkg::OFF_COUNT_LO;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        bkp_rst_n = 1'b0;
    logic [1:0]  src_sel = bdr_pkg::SRC_NONE;
    logic        cmd_valid = 1'b0;
    logic        cmd_write = 1'b0;
    logic [7:0]  cmd_addr = 8'h00;
    logic [31:0] cmd_wdata = 32'h0;
    logic        cmd_ready, rsp_valid, rsp_err, irq, alarm_line;
    logic [31:0] rsp_rdata, rd_q, first_q;
    logic [31:0] cyc = 32'h0;
    int          err_count = 0;
    int          cmp_count = 0;

    bdr_apb_if bus_if ();

    always #2.5 clk = ~clk;
    // Source pin periods 8, 16, 20 bus cycles, all four or more
    always @(posedge clk) cyc <= cyc + 32'h1;

    bdr_device i_bdr_device (.CLK(clk), .RST_N(rst_n), .BKP_RST_N(bkp_rst_n),
        .SRC_SEL(src_sel), .FAST_XTAL(cyc[2]), .SLOW_XTAL(cyc[3]),
        .INT_OSC(cyc % 20 < 10), .BUS(bus_if), .IRQ(irq),
        .ALARM_LINE(alarm_line));
    bdr_host i_bdr_host (.CLK(clk), .RST_N(rst_n), .BUS(bus_if),
        .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr),
        .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
        .RSP_RDATA(rsp_rdata), .RSP_ERR(rsp_err));
    bdr_chk i_bdr_chk (.CLK(clk), .RST_N(rst_n), .PSEL(bus_if.PSEL),
        .PENABLE(bus_if.PENABLE), .PWRITE(bus_if.PWRITE),
        .PADDR(bus_if.PADDR), .PWDATA(bus_if.PWDATA),
        .PRDATA(bus_if.PRDATA), .PREADY(bus_if.PREADY),
        .PSLVERR(bus_if.PSLVERR));

    task automatic results();
        $display("compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk1(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask : chk1

    // One command, entered and left just after a rising edge
    task automatic cmd(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 50) begin
            err_count++;
            results();
        end
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = d;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 50) begin
            err_count++;
            results();
        end
        rd_q = rsp_rdata;
    endtask : cmd

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        cmd(1'b0, a, 32'h0);
        check(rd_q, exp);
    endtask : rd

    // Polls one control bit; a bounded loop, the hang limit counts as a miss
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            cmd(1'b0, A_CT, 32'h0);
            n++;
        end while (rd_q[b] !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            err_count++;
            results();
        end
    endtask : poll

    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        bkp_rst_n = 1'b1;
        rd(A_CT, 32'h20);
        rd(A_IE, 32'h0);
        rd(8'h28, 32'h0);
        chk1(rsp_err, 1'b1);
        cmd(1'b1, A_IE, 32'hFFFF);
        rd(A_IE, 32'h7);
        $display("test registers done");
        cmd(1'b1, A_CL, 32'h5);
        rd(A_CL, 32'h0);
        cmd(1'b1, A_CT, 32'h10);
        rd(A_CT, 32'h30);
        cmd(1'b1, bdr_pkg::OFF_PRESC_HI, 32'h0);
        cmd(1'b1, bdr_pkg::OFF_PRESC_LO, 32'h3);
        cmd(1'b1, bdr_pkg::OFF_COUNT_HI, 32'hFFFF);
        cmd(1'b1, A_CL, 32'hFFFE);
        cmd(1'b1, bdr_pkg::OFF_ALARM_HI, 32'hFFFF);
        cmd(1'b1, bdr_pkg::OFF_ALARM_LO, 32'hFFFF);
        rd(bdr_pkg::OFF_PRESC_LO, 32'h0);
        cmd(1'b1, A_CT, 32'h0);
        rd(A_CT, 32'h0);
        rd(A_CL, 32'h0);
        src_sel = bdr_pkg::SRC_SLOW;
        poll(5);
        cmd(1'b1, A_CT, 32'h0);
        poll(3);
        rd(bdr_pkg::OFF_COUNT_HI, 32'hFFFF);
        rd(A_CL, 32'hFFFE);
        poll(0);
        check(rd_q, 32'h29);
        chk1(irq, 1'b1);
        cmd(1'b1, A_CT, 32'hF);
        rd(A_CT, 32'h29);
        cmd(1'b1, A_CT, 32'h8);
        rd(A_CT, 32'h28);
        chk1(irq, 1'b0);
        poll(0);
        check(rd_q, 32'h2F);
        chk1(alarm_line, 1'b1);
        cmd(1'b1, A_IE, 32'h0);
        // Interrupt lines are registered one cycle behind flags and enables
        @(posedge clk);
        #1 chk1(irq, 1'b0);
        cmd(1'b1, A_IE, 32'h2);
        @(posedge clk);
        #1 chk1(irq, 1'b1);
        cmd(1'b1, A_CT, 32'h0);
        @(posedge clk);
        #1 chk1(alarm_line, 1'b0);
        chk1(irq, 1'b0);
        $display("test flags done");
        // Counter must move under every source but the none setting
        for (int s = 0; s < 4; s++) begin
            src_sel = s[1:0];
            cmd(1'b0, A_CL, 32'h0);
            first_q = rd_q;
            repeat (9000) @(posedge clk);
            #1 cmd(1'b0, A_CL, 32'h0);
            chk1(rd_q != first_q, s != 0);
        end
        $display("test sources done");
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        rd(A_IE, 32'h0);
        $display("test system reset done");
        results();
    end
endmodule : tb_backup_domain_rtc
